//--- include/hpt_map.vh
// Purpose: Offsets, reset values, field positions and code tables of the
//          hub transceiver tuning registers.
// Assumes: Byte-wide registers on an 8-bit register address.
// Notes:   Definitions only.
`ifndef HPT_MAP_VH
`define HPT_MAP_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define HPT_OFS_SQUELCH_21 8'hf5
`define HPT_OFS_BOOST_3 8'hf6
`define HPT_OFS_BOOST_21 8'hf8
`define HPT_OFS_SWAP 8'hfa

// ---------------------------------------------------------------
// Reset values and writable masks
// ---------------------------------------------------------------
`define HPT_RST_SQUELCH_21 8'h00
`define HPT_RST_BOOST_3 8'h30
`define HPT_RST_BOOST_21 8'h00
`define HPT_RST_SWAP 8'h00
`define HPT_MSK_SQUELCH_21 8'h77
`define HPT_MSK_BOOST_3 8'h07
`define HPT_MSK_BOOST_21 8'h77
`define HPT_MSK_SWAP 8'h0e
`define HPT_RD_ZERO 8'h00

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define HPT_HI_MSB 6
`define HPT_HI_LSB 4
`define HPT_LO_MSB 2
`define HPT_LO_LSB 0
`define HPT_SWAP_P1 1
`define HPT_SWAP_P2 2
`define HPT_SWAP_P3 3

// ---------------------------------------------------------------
// Squelch threshold, percent of nominal
// ---------------------------------------------------------------
`define HPT_SQ_000 8'h64
`define HPT_SQ_001 8'h5a
`define HPT_SQ_010 8'h50
`define HPT_SQ_011 8'h46
`define HPT_SQ_100 8'h3c
`define HPT_SQ_101 8'h32
`define HPT_SQ_110 8'h78
`define HPT_SQ_111 8'h6e

// ---------------------------------------------------------------
// Drive boost, signed percent change from nominal
// ---------------------------------------------------------------
`define HPT_BS_000 8'h00
`define HPT_BS_001 8'hfb
`define HPT_BS_010 8'h0a
`define HPT_BS_011 8'h05
`define HPT_BS_100 8'h14
`define HPT_BS_101 8'h0f
`define HPT_BS_110 8'h1e
`define HPT_BS_111 8'h19

`endif

//--- design/hpt_swap_lane.v
// Purpose: One downstream port's DP/DM role exchange.
// Assumes: Line inputs come from pins; transmit side from core logic.
// Notes:   All outputs registered; pin inputs pass two flops first.
`timescale 1ns/10ps
`default_nettype none

module hpt_swap_lane (
   input wire ref_clk,
   input wire resetn,
   input wire swap_en,
   input wire tx_pos,
   input wire tx_neg,
   input wire tx_drive,
   input wire dp_in,
   input wire dm_in,
   output reg dp_out,
   output reg dm_out,
   output reg dp_oe_n,
   output reg dm_oe_n,
   output reg rx_pos,
   output reg rx_neg
);

   reg dp_meta_q;
   reg dm_meta_q;
   reg dp_sync_q;
   reg dm_sync_q;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (!resetn) begin
         dp_meta_q <= 1'b0;
         dm_meta_q <= 1'b0;
         dp_sync_q <= 1'b0;
         dm_sync_q <= 1'b0;
      end else begin
         dp_meta_q <= dp_in;
         dm_meta_q <= dm_in;
         dp_sync_q <= dp_meta_q;
         dm_sync_q <= dm_meta_q;
      end
   end

   // ---------------------------------------------------------------
   // Role selection
   // ---------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (!resetn) begin
         dp_out <= 1'b0;
         dm_out <= 1'b0;
         dp_oe_n <= 1'b1;
         dm_oe_n <= 1'b1;
         rx_pos <= 1'b0;
         rx_neg <= 1'b0;
      end else begin
         dp_oe_n <= ~tx_drive;
         dm_oe_n <= ~tx_drive;
         if (swap_en) begin
            dp_out <= tx_neg;
            dm_out <= tx_pos;
            rx_pos <= dm_sync_q;
            rx_neg <= dp_sync_q;
         end else begin
            dp_out <= tx_pos;
            dm_out <= tx_neg;
            rx_pos <= dp_sync_q;
            rx_neg <= dm_sync_q;
         end
      end
   end

endmodule // hpt_swap_lane

`default_nettype wire

//--- design/hpt_regs.v
// Purpose: Transceiver tuning registers of a three-port hub: squelch,
//          high-speed drive boost and DP/DM role exchange.
// Assumes: Register port is driven by the serial configuration slave on
//          ref_clk; pins are asynchronous.
// Notes:   Read data is registered, one cycle after the read strobe.
`timescale 1ns/10ps
`default_nettype none
`include "hpt_map.vh"

// Contract
// - Squelch register bits 6:4 set port 2 squelch; nominal, 90..50%, 120%, 110%.
// - Squelch register bits 2:0 set port 1 squelch on the same scale.
// - Port 3 boost bits 2:0 set drive: 0,-5,+10,+5,+20,+15,+30,+25 percent.
// - Boost register bits 6:4 set port 2 drive current; 000 nominal.
// - Boost register bits 2:0 set port 1 drive current, same encoding.
// - Swap bit zero keeps positive line on DP and negative on DM.
// - Swap bit one puts positive line on DM and negative on DP.
// - Swap bits 3,2,1 serve ports 3,2,1; other bits have no effect.
module hpt_regs (
   input wire ref_clk,
   input wire resetn,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   output reg reg_rvalid,
   output reg reg_hit,
   output reg [2:0] port_one_squelch_level,
   output reg [2:0] port_two_squelch_level,
   output reg [7:0] port_one_squelch_pct,
   output reg [7:0] port_two_squelch_pct,
   output reg [2:0] port_one_drive_boost,
   output reg [2:0] port_two_drive_boost,
   output reg [2:0] port_three_drive_boost,
   output reg [7:0] port_one_boost_pct,
   output reg [7:0] port_two_boost_pct,
   output reg [7:0] port_three_boost_pct,
   output reg [2:0] line_polarity_swap,
   input wire [2:0] tx_pos,
   input wire [2:0] tx_neg,
   input wire [2:0] tx_drive,
   input wire [2:0] dp_in,
   input wire [2:0] dm_in,
   output wire [2:0] dp_out,
   output wire [2:0] dm_out,
   output wire [2:0] dp_oe_n,
   output wire [2:0] dm_oe_n,
   output wire [2:0] rx_pos,
   output wire [2:0] rx_neg
);

   localparam NPORTS = 3;

   reg [7:0] squelch_ports_two_one_q;
   reg [7:0] drive_boost_port_three_q;
   reg [7:0] drive_boost_ports_two_one_q;
   reg [7:0] line_polarity_swap_q;
   reg [7:0] rdata_d;
   reg hit_d;

   // ---------------------------------------------------------------
   // Code tables
   // ---------------------------------------------------------------
   function [7:0] squelch_pct;
      input [2:0] code;
      begin
         case (code)
            3'h0: squelch_pct = `HPT_SQ_000;
            3'h1: squelch_pct = `HPT_SQ_001;
            3'h2: squelch_pct = `HPT_SQ_010;
            3'h3: squelch_pct = `HPT_SQ_011;
            3'h4: squelch_pct = `HPT_SQ_100;
            3'h5: squelch_pct = `HPT_SQ_101;
            3'h6: squelch_pct = `HPT_SQ_110;
            3'h7: squelch_pct = `HPT_SQ_111;
            default: squelch_pct = `HPT_SQ_000;
         endcase
      end
   endfunction

   // Port 2 uses this table too; its printed codes are partly garbled,
   // and the shared table agrees with every code that is legible.
   function [7:0] boost_pct;
      input [2:0] code;
      begin
         case (code)
            3'h0: boost_pct = `HPT_BS_000;
            3'h1: boost_pct = `HPT_BS_001;
            3'h2: boost_pct = `HPT_BS_010;
            3'h3: boost_pct = `HPT_BS_011;
            3'h4: boost_pct = `HPT_BS_100;
            3'h5: boost_pct = `HPT_BS_101;
            3'h6: boost_pct = `HPT_BS_110;
            3'h7: boost_pct = `HPT_BS_111;
            default: boost_pct = `HPT_BS_000;
         endcase
      end
   endfunction

   // ---------------------------------------------------------------
   // Register writes
   // ---------------------------------------------------------------
   // Masking on write clears reserved flops, but reset loads 0x30 into the port 3 boost register; reads apply no mask.
   always @(posedge ref_clk) begin
      if (!resetn) begin
         squelch_ports_two_one_q <= `HPT_RST_SQUELCH_21;
         drive_boost_port_three_q <= `HPT_RST_BOOST_3;
         drive_boost_ports_two_one_q <= `HPT_RST_BOOST_21;
         line_polarity_swap_q <= `HPT_RST_SWAP;
      end else if (reg_wr) begin
         case (reg_addr)
            `HPT_OFS_SQUELCH_21: begin
               squelch_ports_two_one_q <=
                  reg_wdata & `HPT_MSK_SQUELCH_21;
            end
            `HPT_OFS_BOOST_3: begin
               drive_boost_port_three_q <=
                  reg_wdata & `HPT_MSK_BOOST_3;
            end
            `HPT_OFS_BOOST_21: begin
               drive_boost_ports_two_one_q <=
                  reg_wdata & `HPT_MSK_BOOST_21;
            end
            `HPT_OFS_SWAP: begin
               line_polarity_swap_q <= reg_wdata & `HPT_MSK_SWAP;
            end
            default: begin
               line_polarity_swap_q <= line_polarity_swap_q;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Register reads
   // ---------------------------------------------------------------
   always @* begin
      rdata_d = `HPT_RD_ZERO;
      hit_d = 1'b1;
      case (reg_addr)
         `HPT_OFS_SQUELCH_21: rdata_d = squelch_ports_two_one_q;
         `HPT_OFS_BOOST_3: rdata_d = drive_boost_port_three_q;
         `HPT_OFS_BOOST_21: rdata_d = drive_boost_ports_two_one_q;
         `HPT_OFS_SWAP: rdata_d = line_polarity_swap_q;
         default: begin
            // Other offsets belong to neighbouring blocks
            rdata_d = `HPT_RD_ZERO;
            hit_d = 1'b0;
         end
      endcase
   end

   always @(posedge ref_clk) begin
      if (!resetn) begin
         reg_rdata <= `HPT_RD_ZERO;
         reg_rvalid <= 1'b0;
         reg_hit <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= rdata_d;
            reg_hit <= hit_d;
         end
      end
   end

   // ---------------------------------------------------------------
   // Tuning outputs
   // ---------------------------------------------------------------
   // One cycle behind the register so every output leaves a flop.
   always @(posedge ref_clk) begin
      if (!resetn) begin
         port_one_squelch_level <= 3'h0;
         port_two_squelch_level <= 3'h0;
         port_one_squelch_pct <= `HPT_SQ_000;
         port_two_squelch_pct <= `HPT_SQ_000;
         port_one_drive_boost <= 3'h0;
         port_two_drive_boost <= 3'h0;
         port_three_drive_boost <= 3'h0;
         port_one_boost_pct <= `HPT_BS_000;
         port_two_boost_pct <= `HPT_BS_000;
         port_three_boost_pct <= `HPT_BS_000;
         line_polarity_swap <= 3'h0;
      end else begin
         port_two_squelch_level <=
            squelch_ports_two_one_q[`HPT_HI_MSB:`HPT_HI_LSB];
         port_two_squelch_pct <= squelch_pct(
            squelch_ports_two_one_q[`HPT_HI_MSB:`HPT_HI_LSB]);
         port_one_squelch_level <=
            squelch_ports_two_one_q[`HPT_LO_MSB:`HPT_LO_LSB];
         port_one_squelch_pct <= squelch_pct(
            squelch_ports_two_one_q[`HPT_LO_MSB:`HPT_LO_LSB]);
         port_three_drive_boost <=
            drive_boost_port_three_q[`HPT_LO_MSB:`HPT_LO_LSB];
         port_three_boost_pct <= boost_pct(
            drive_boost_port_three_q[`HPT_LO_MSB:`HPT_LO_LSB]);
         port_two_drive_boost <=
            drive_boost_ports_two_one_q[`HPT_HI_MSB:`HPT_HI_LSB];
         port_two_boost_pct <= boost_pct(
            drive_boost_ports_two_one_q[`HPT_HI_MSB:`HPT_HI_LSB]);
         port_one_drive_boost <=
            drive_boost_ports_two_one_q[`HPT_LO_MSB:`HPT_LO_LSB];
         port_one_boost_pct <= boost_pct(
            drive_boost_ports_two_one_q[`HPT_LO_MSB:`HPT_LO_LSB]);
         line_polarity_swap <= {
            line_polarity_swap_q[`HPT_SWAP_P3],
            line_polarity_swap_q[`HPT_SWAP_P2],
            line_polarity_swap_q[`HPT_SWAP_P1]};
      end
   end

   // ---------------------------------------------------------------
   // Line role exchange, one lane per downstream port
   // ---------------------------------------------------------------
   // The lane takes its swap bit straight from the register; a swap
   // change mid-packet corrupts that packet, so software changes it
   // only while the port is idle.
   genvar gi;
   generate
      for (gi = 0; gi < NPORTS; gi = gi + 1) begin : g_lane
         hpt_swap_lane u_lane (
            .ref_clk(ref_clk),
            .resetn(resetn),
            .swap_en(line_polarity_swap_q[`HPT_SWAP_P1 + gi]),
            .tx_pos(tx_pos[gi]),
            .tx_neg(tx_neg[gi]),
            .tx_drive(tx_drive[gi]),
            .dp_in(dp_in[gi]),
            .dm_in(dm_in[gi]),
            .dp_out(dp_out[gi]),
            .dm_out(dm_out[gi]),
            .dp_oe_n(dp_oe_n[gi]),
            .dm_oe_n(dm_oe_n[gi]),
            .rx_pos(rx_pos[gi]),
            .rx_neg(rx_neg[gi])
         );
      end
   endgenerate

endmodule // hpt_regs

`default_nettype wire

//--- verif/hpt_regs_props.sv
// Purpose: Assertions on the tuning register port and pin lanes
// Assumes: Tuning outputs settle one edge after the write edge, sampled at the second
// Notes:   Bound to hpt_regs below the module
`timescale 1ns/10ps
`default_nettype none
module hpt_regs_props (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic reg_hit,
   input wire logic [7:0] port_one_squelch_pct,
   input wire logic [7:0] port_two_squelch_pct,
   input wire logic [7:0] port_one_boost_pct,
   input wire logic [7:0] port_two_boost_pct,
   input wire logic [7:0] port_three_boost_pct,
   input wire logic [2:0] line_polarity_swap,
   input wire logic [2:0] tx_pos,
   input wire logic [2:0] tx_neg,
   input wire logic [2:0] dp_out,
   input wire logic [2:0] dm_out
);
   // ----
   // Code tables
   // ----
   localparam logic [7:0] sq_t [0:7] = '{8'h64, 8'h5a, 8'h50, 8'h46,
      8'h3c, 8'h32, 8'h78, 8'h6e};
   localparam logic [7:0] bs_t [0:7] = '{8'h00, 8'hfb, 8'h0a, 8'h05,
      8'h14, 8'h0f, 8'h1e, 8'h19};
   logic wr_sq, wr_b3, wr_b21, wr_sw, rd_miss;
   assign wr_sq = reg_wr && reg_addr == 8'hf5;
   assign wr_b3 = reg_wr && reg_addr == 8'hf6;
   assign wr_b21 = reg_wr && reg_addr == 8'hf8;
   assign wr_sw = reg_wr && reg_addr == 8'hfa;
   assign rd_miss = reg_rd && !(reg_addr inside {8'hf5, 8'hf6, 8'hf8,
      8'hfa});
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // ----
   // Properties
   // ----
   a_read_valid: assert property (reg_rd |=> reg_rvalid)
      else $error("read strobe gave no valid");
   a_unmapped_zero: assert property (rd_miss |=>
      reg_rdata == 8'h00 && !reg_hit) else $error("unmapped read not zero");
   a_top_bit_zero: assert property (reg_rvalid |-> !reg_rdata[7])
      else $error("reserved top bit read as one");
   a_squelch_two: assert property (wr_sq |-> ##2
      port_two_squelch_pct == sq_t[$past(reg_wdata[6:4], 2)])
      else $error("port two squelch wrong");
   a_squelch_one: assert property (wr_sq |-> ##2
      port_one_squelch_pct == sq_t[$past(reg_wdata[2:0], 2)])
      else $error("port one squelch wrong");
   a_boost_three: assert property (wr_b3 |-> ##2
      port_three_boost_pct == bs_t[$past(reg_wdata[2:0], 2)])
      else $error("port three boost wrong");
   a_boost_one: assert property (wr_b21 |-> ##2
      port_one_boost_pct == bs_t[$past(reg_wdata[2:0], 2)])
      else $error("port one boost wrong");
   a_boost_two: assert property (wr_b21 &&
      reg_wdata[6:4] inside {3'h0, 3'h2, 3'h7} |-> ##2
      port_two_boost_pct == bs_t[$past(reg_wdata[6:4], 2)])
      else $error("port two boost wrong");
   a_swap_bits: assert property (wr_sw |-> ##2
      line_polarity_swap == $past(reg_wdata[3:1], 2))
      else $error("swap bits mapped wrong");
   a_lane_roles: assert property ($past(resetn) &&
      $stable(line_polarity_swap) |->
      dp_out == ((~line_polarity_swap & $past(tx_pos)) |
      (line_polarity_swap & $past(tx_neg))) &&
      dm_out == ((~line_polarity_swap & $past(tx_neg)) |
      (line_polarity_swap & $past(tx_pos))))
      else $error("lane line roles wrong");
   c_read_hit: cover property (reg_rvalid && reg_hit);
   c_swap_all: cover property (line_polarity_swap == 3'h7);
   c_write_pair: cover property (reg_wr ##1 reg_wr);
endmodule // hpt_regs_props

bind hpt_regs hpt_regs_props hpt_regs_props_i (.ref_clk(ref_clk),
   .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .reg_rvalid(reg_rvalid), .reg_hit(reg_hit),
   .port_one_squelch_pct(port_one_squelch_pct),
   .port_two_squelch_pct(port_two_squelch_pct),
   .port_one_boost_pct(port_one_boost_pct),
   .port_two_boost_pct(port_two_boost_pct),
   .port_three_boost_pct(port_three_boost_pct),
   .line_polarity_swap(line_polarity_swap), .tx_pos(tx_pos),
   .tx_neg(tx_neg), .dp_out(dp_out), .dm_out(dm_out));
`default_nettype wire

//--- verif/test_hpt_regs.sv
// Purpose: Self-checking bench for the hub tuning registers
// Assumes: One strobe per cycle except the final write-and-read test, inputs driven 1 ns after the edge
// Notes:   Rows cover write masks; code, swap and reset tests follow
`timescale 1ns/10ps
`default_nettype none
module test_hpt_regs;
   logic ref_clk, resetn, reg_wr, reg_rd;
   logic [7:0] reg_addr, reg_wdata;
   logic [2:0] tx_pos, tx_neg, tx_drive, dp_in, dm_in;
   wire [7:0] reg_rdata, sq1, sq2, b1, b2, b3;
   wire reg_rvalid, reg_hit;
   wire [2:0] sl1, sl2, bl1, bl2, bl3, sw, dpo, dmo, dpe, dme, rxp, rxn;
   int err_count, checks, cyc;
   logic [31:0] rows [0:8] = '{32'hf5ff7701, 32'hf6ff0701, 32'hf8ff7701,
      32'hfaff0e01, 32'h3cff0000, 32'hf5880001, 32'hf6f80001,
      32'hf85a5201, 32'hfaa50401};
   logic [7:0] sq_t [0:7] = '{8'h64, 8'h5a, 8'h50, 8'h46, 8'h3c, 8'h32,
      8'h78, 8'h6e};
   logic [7:0] bs_t [0:7] = '{8'h00, 8'hfb, 8'h0a, 8'h05, 8'h14, 8'h0f,
      8'h1e, 8'h19};
   hpt_regs hpt_regs_i (.ref_clk(ref_clk), .resetn(resetn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .reg_hit(reg_hit), .port_one_squelch_level(sl1),
      .port_two_squelch_level(sl2), .port_one_squelch_pct(sq1),
      .port_two_squelch_pct(sq2), .port_one_drive_boost(bl1),
      .port_two_drive_boost(bl2), .port_three_drive_boost(bl3),
      .port_one_boost_pct(b1), .port_two_boost_pct(b2),
      .port_three_boost_pct(b3), .line_polarity_swap(sw),
      .tx_pos(tx_pos), .tx_neg(tx_neg), .tx_drive(tx_drive),
      .dp_in(dp_in), .dm_in(dm_in), .dp_out(dpo), .dm_out(dmo),
      .dp_oe_n(dpe), .dm_oe_n(dme), .rx_pos(rxp), .rx_neg(rxn));
   // ----
   // Clock and hang guard
   // ----
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 2000) begin
         err_count++;
         give_verdict;
      end
   end
   // ----
   // Tasks
   // ----
   task give_verdict;
      begin
         $display("checks %0d errors %0d", checks, err_count);
         if (err_count == 0 && checks > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   task chk(input logic [7:0] got, exp);
      begin
         checks++;
         if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   task chk3(input logic [2:0] got, exp);
      chk({5'h0, got}, {5'h0, exp});
   endtask
   task step(input int n);
      begin
         repeat (n) @(posedge ref_clk);
         #1;
      end
   endtask
   // An idle edge first, so a strobe is never lowered and raised at once
   task wr(input logic [7:0] a, d);
      begin
         step(1);
         reg_addr = a;
         reg_wdata = d;
         reg_wr = 1'b1;
         step(1);
         reg_wr = 1'b0;
      end
   endtask
   task rd(input logic [7:0] a, q, input logic h);
      begin
         step(1);
         reg_addr = a;
         reg_rd = 1'b1;
         step(1);
         reg_rd = 1'b0;
         chk({7'h0, reg_rvalid}, 8'h01);
         chk(reg_rdata, q);
         chk({7'h0, reg_hit}, {7'h0, h});
      end
   endtask
   // ----
   // Main sequence
   // ----
   initial begin
      {resetn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      {tx_pos, tx_neg, tx_drive, dp_in, dm_in} = '0;
      step(8);
      resetn = 1'b1;
      foreach (rows[i]) begin
         wr(rows[i][31:24], rows[i][23:16]);
         rd(rows[i][31:24], rows[i][15:8], rows[i][0]);
      end
      // Port 1 fields get code 7-c against c for ports 2 and 3, so a crossed field shows
      for (int c = 0; c < 8; c++) begin
         wr(8'hf5, {1'b0, c[2:0], 1'b0, 3'(7 - c)});
         wr(8'hf6, {5'h1f, c[2:0]});
         wr(8'hf8, {1'b1, c[2:0], 1'b1, 3'(7 - c)});
         step(2);
         chk(sq2, sq_t[c]);
         chk(sq1, sq_t[7 - c]);
         chk(b3, bs_t[c]);
         chk(b1, bs_t[7 - c]);
         chk3(sl2, c[2:0]);
         chk3(sl1, 3'(7 - c));
         chk3(bl3, c[2:0]);
         chk3(bl2, c[2:0]);
         chk3(bl1, 3'(7 - c));
         if (c == 0 || c == 2 || c == 7)
            chk(b2, bs_t[c]);
      end
      dp_in = 3'h3;
      dm_in = 3'h4;
      tx_drive = 3'h6;
      for (int s = 0; s < 8; s++) begin
         tx_pos = 3'(s) ^ 3'h5;
         tx_neg = ~tx_pos;
         // Reserved bits set too; they must not move any lane
         wr(8'hfa, {4'hf, s[2:0], 1'b1});
         step(5);
         chk3(sw, s[2:0]);
         chk3(dpo, (tx_pos & ~s[2:0]) | (tx_neg & s[2:0]));
         chk3(dmo, (tx_neg & ~s[2:0]) | (tx_pos & s[2:0]));
         chk3(rxp, (dp_in & ~s[2:0]) | (dm_in & s[2:0]));
         chk3(rxn, (dm_in & ~s[2:0]) | (dp_in & s[2:0]));
         chk3(dpe, ~tx_drive);
         chk3(dme, ~tx_drive);
      end
      // Second reset in mid-run, then the reset values
      resetn = 1'b0;
      step(2);
      resetn = 1'b1;
      rd(8'hf5, 8'h00, 1'b1);
      rd(8'hf6, 8'h30, 1'b1);
      rd(8'hf8, 8'h00, 1'b1);
      rd(8'hfa, 8'h00, 1'b1);
      chk(sq1, 8'h64);
      chk(b3, 8'h00);
      // Write and read together return the old byte
      step(1);
      reg_addr = 8'hf5;
      reg_wdata = 8'h11;
      reg_wr = 1'b1;
      reg_rd = 1'b1;
      step(1);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      chk(reg_rdata, 8'h00);
      rd(8'hf5, 8'h11, 1'b1);
      give_verdict;
   end
endmodule // test_hpt_regs
`default_nettype wire
